//--- hdl/shp_consts.svh
// Purpose: constants of the slave host port: status fields, commands, opcodes, resets
// Assumes: 8-bit host data bus, 8-bit port 2
// Notes:   definitions only
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH

// ------------------------------------------------------------
// host_status field positions
// ------------------------------------------------------------
`define SHP_STS_OBF_BIT      0
`define SHP_STS_IBF_BIT      1
`define SHP_STS_F0_BIT       2
`define SHP_STS_CMD_BIT      3
`define SHP_STS_USER_LSB     4
`define SHP_STS_USER_MSB     7

// ------------------------------------------------------------
// port 2 bit positions
// ------------------------------------------------------------
`define SHP_P2_GATE_BIT      1
`define SHP_P2_OUT_FLAG_BIT  4
`define SHP_P2_IN_FLAG_BIT   5
`define SHP_P2_REQ_BIT       6
`define SHP_P2_ACK_BIT       7

// ------------------------------------------------------------
// host commands and CPU opcodes
// ------------------------------------------------------------
`define SHP_CMD_GATE         8'hD1
`define SHP_CMD_END          8'hFF
`define SHP_OP_EN_DMA        8'hE5
`define SHP_OP_GATE_EN       8'h33

// ------------------------------------------------------------
// reset values and buffer shape
// ------------------------------------------------------------
`define SHP_RST_BYTE         8'h00
`define SHP_RST_PORT2        8'hFF
`define SHP_RST_USER         4'h0
`define SHP_DATA_W           8
`define SHP_FIFO_DEPTH       16

`endif

//--- hdl/shp_pkg.sv
// Purpose: types of the slave host port
// Assumes: nothing
// Notes:   constants live in shp_consts.svh
package shp_pkg;

   // ------------------------------------------------------------
   // gate command sequence tracker
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SHP_GS_IDLE  = 2'b00,
      SHP_GS_ARMED = 2'b01,
      SHP_GS_DONE  = 2'b10
   } shp_gate_state_t;

endpackage

//--- hdl/shp_host_port.sv
// Purpose: host-side buffers, status, flag/DMA pins and gate logic of a slave controller
// Assumes: host pins asynchronous to i_ref_clk; CPU-side inputs on i_ref_clk
// Notes:   host strobes must stay active at least three clock periods
`timescale 1ns/1ps
`include "shp_consts.svh"

// ------------------------------------------------------------
// output word queue
// ------------------------------------------------------------
module shp_fifo #(
   parameter int WIDTH = `SHP_DATA_W,
   parameter int DEPTH = `SHP_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rstn,
   // fill side
   input  wire logic [WIDTH-1:0] i_in_data,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   // drain side
   output logic      [WIDTH-1:0] o_out_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    wr_ptr_next;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW-1:0]    rd_ptr_next;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign o_in_ready  = (count_reg != (AW + 1)'(DEPTH));
   assign o_out_valid = (count_reg != '0);
   assign o_out_data  = mem_reg[rd_ptr_reg];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always_comb begin
      mem_next    = mem_reg;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next  = count_reg;
      if (push) begin
         mem_next[wr_ptr_reg] = i_in_data;
         wr_ptr_next          = ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
         rd_ptr_next = ptr_inc(rd_ptr_reg);
      end
      if (push & ~pop) begin
         count_next = count_reg + (AW + 1)'(1);
      end else if (pop & ~push) begin
         count_next = count_reg - (AW + 1)'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         mem_reg    <= mem_next;
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
      end
   end
endmodule

// Overview of operation
// - separate input buffer written by host and output buffer read by host
// - 8-bit status; move-to-status copies accumulator bits 4-7, keeps bits 0-3
// - strobes are edges; flags change only after the strobe's trailing edge
// - status updates held off while the host reads status, applied afterwards
// - flag pins are plain port pins until enable-flags executes
// - flags on: port bit 4 latch 1 shows output-full, 0 forces low
// - flags on: port bit 5 latch 1 shows inverse input-full, 0 forces low
// - DMA pins are plain port pins until enable-DMA opcode E5 executes
// - DMA mode: writing bit 6 high requests; ack with strobe or E5 clears
// - DMA mode: active-low acknowledge on bit 7 acts as a chip select; A0 still picks status or data
// - gate enable lasts until reset; port bit 1 changes only by host sequence
// - gate command D1 plus data handled without CPU; input-full never set
// - completing data write copies only data bit 1 to gate output
// - FF ending a valid sequence changes nothing; other FF sets input-full
// - drive data only while selected and reading; take data only when writing
module shp_host_port #(
   parameter logic [7:0] P_OP_EN_FLAGS = 8'h01,
   parameter logic [7:0] P_OP_MOV_STS  = 8'h02
) (
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rstn,
   // host bus pins
   input  wire logic       i_cs_n,
   input  wire logic       i_rd_n,
   input  wire logic       i_wr_n,
   input  wire logic       i_command_select_line,
   input  wire logic [7:0] i_host_data_buffer,
   output logic      [7:0] o_host_data_buffer,
   output logic            o_host_data_buffer_oe_n,
   // port 2 pins
   input  wire logic       i_acknowledge_port_pin_n,
   output logic      [7:0] o_port2,
   // CPU instruction strobe
   input  wire logic       i_op_valid,
   input  wire logic [7:0] i_op,
   input  wire logic [7:0] i_acc,
   input  wire logic       i_p2_wr,
   input  wire logic [7:0] i_p2_data,
   // CPU input buffer side
   input  wire logic       i_cpu_in_rd,
   output logic      [7:0] o_cpu_in_data,
   output logic            o_input_full_flag,
   output logic            o_command_data_flag,
   // CPU output buffer side
   input  wire logic [7:0] i_cpu_out_data,
   input  wire logic       i_cpu_out_valid,
   output logic            o_cpu_out_ready,
   output logic            o_output_full_flag
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [12:0] pin_s1_reg;
   logic [12:0] pin_s2_reg;
   logic [7:0]  db_s;
   logic        ack_n_s;
   logic        a0_s;
   logic        cs_n_s;
   logic        rd_n_s;
   logic        wr_n_s;

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_s1_reg <= 13'h1F00;
         pin_s2_reg <= 13'h1F00;
      end else begin
         pin_s1_reg <= {i_acknowledge_port_pin_n, i_command_select_line, i_cs_n, i_rd_n,
                        i_wr_n, i_host_data_buffer};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   assign {ack_n_s, a0_s, cs_n_s, rd_n_s, wr_n_s, db_s} = pin_s2_reg;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic                     dma_en_reg,    dma_en_next;
   logic                     flags_en_reg,  flags_en_next;
   logic                     gate_en_reg,   gate_en_next;
   logic                     gate_reg,      gate_next;
   shp_pkg::shp_gate_state_t gs_reg,        gs_next;
   logic                     drq_reg,       drq_next;
   logic [7:0]               p2_latch_reg,  p2_latch_next;
   logic [7:0]               p2_out_reg,    p2_out_next;
   logic [7:0]               in_buf_reg,    in_buf_next;
   logic [7:0]               out_buf_reg,   out_buf_next;
   logic                     ibf_reg,       ibf_next;
   logic                     obf_reg,       obf_next;
   logic                     cmd_reg,       cmd_next;
   logic [3:0]               user_reg,      user_next;
   logic                     pend_user_reg, pend_user_next;
   logic [3:0]               pend_val_reg,  pend_val_next;
   logic                     pend_clr_reg,  pend_clr_next;
   logic                     wr_seen_reg,   wr_seen_next;
   logic                     rd_seen_reg,   rd_seen_next;
   logic [7:0]               wl_data_reg,   wl_data_next;
   logic                     wl_a0_reg,     wl_a0_next;
   logic                     wl_ack_reg,    wl_ack_next;
   logic                     rl_a0_reg,     rl_a0_next;
   logic                     rl_ack_reg,    rl_ack_next;
   logic [7:0]               db_out_reg,    db_out_next;
   logic                     oe_n_reg,      oe_n_next;

   logic       ack_sel;
   logic       sel;
   logic       rd_act;
   logic       wr_act;
   logic       wr_end;
   logic       rd_end;
   logic       lock;
   logic       op_dma;
   logic       op_flags;
   logic       op_gate;
   logic       op_sts;
   logic       swallow;
   logic       ibf_clr;
   logic       fifo_pop;
   logic [7:0] fifo_data;
   logic       fifo_valid;
   logic [7:0] status;

   function automatic logic [7:0] pack_status(input logic [3:0] user, input logic cmd,
                                              input logic input_full_flag, input logic output_full_flag);
      pack_status                           = 8'h00;
      pack_status[`SHP_STS_USER_MSB:`SHP_STS_USER_LSB] = user;
      pack_status[`SHP_STS_CMD_BIT]         = cmd;
      pack_status[`SHP_STS_IBF_BIT]         = input_full_flag;
      pack_status[`SHP_STS_OBF_BIT]         = output_full_flag;
   endfunction

   // ------------------------------------------------------------
   // host strobe decode
   // ------------------------------------------------------------
   assign ack_sel  = dma_en_reg & ~ack_n_s;
   assign sel      = ~cs_n_s | ack_sel;
   assign rd_act   = sel & ~rd_n_s;
   assign wr_act   = sel & ~wr_n_s;
   // trailing edge is the end of an active strobe, so flags move only then
   assign wr_end   = wr_seen_reg & ~wr_act;
   assign rd_end   = rd_seen_reg & ~rd_act;
   assign lock     = rd_act & a0_s;
   assign op_dma   = i_op_valid & (i_op == `SHP_OP_EN_DMA);
   assign op_flags = i_op_valid & (i_op == P_OP_EN_FLAGS);
   assign op_gate  = i_op_valid & (i_op == `SHP_OP_GATE_EN);
   assign op_sts   = i_op_valid & (i_op == P_OP_MOV_STS);
   assign ibf_clr  = (i_cpu_in_rd | pend_clr_reg) & ~lock;
   // output buffer refills from the queue only when empty and unlocked
   assign fifo_pop = fifo_valid & ~obf_reg & ~lock;
   assign status   = pack_status(user_reg, cmd_reg, ibf_reg, obf_reg);

   // ------------------------------------------------------------
   // strobe latches and data bus drive
   // ------------------------------------------------------------
   always_comb begin
      wr_seen_next = wr_act;
      rd_seen_next = rd_act;
      wl_data_next = wl_data_reg;
      wl_a0_next   = wl_a0_reg;
      wl_ack_next  = wl_ack_reg;
      rl_a0_next   = rl_a0_reg;
      rl_ack_next  = rl_ack_reg;
      // latch while active; pins may already move at the trailing edge
      if (wr_act) begin
         wl_data_next = db_s;
         wl_a0_next   = a0_s;
         wl_ack_next  = ack_sel;
      end
      if (rd_act) begin
         rl_a0_next  = a0_s;
         rl_ack_next = ack_sel;
      end
      oe_n_next   = ~rd_act;
      db_out_next = a0_s ? status : out_buf_reg;
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_seen_reg <= 1'b0;
         rd_seen_reg <= 1'b0;
         wl_data_reg <= `SHP_RST_BYTE;
         wl_a0_reg   <= 1'b0;
         wl_ack_reg  <= 1'b0;
         rl_a0_reg   <= 1'b0;
         rl_ack_reg  <= 1'b0;
         oe_n_reg    <= 1'b1;
         db_out_reg  <= `SHP_RST_BYTE;
      end else begin
         wr_seen_reg <= wr_seen_next;
         rd_seen_reg <= rd_seen_next;
         wl_data_reg <= wl_data_next;
         wl_a0_reg   <= wl_a0_next;
         wl_ack_reg  <= wl_ack_next;
         rl_a0_reg   <= rl_a0_next;
         rl_ack_reg  <= rl_ack_next;
         oe_n_reg    <= oe_n_next;
         db_out_reg  <= db_out_next;
      end
   end

   // ------------------------------------------------------------
   // buffers, status and gate sequence
   // ------------------------------------------------------------
   always_comb begin
      gs_next        = gs_reg;
      gate_next      = gate_reg;
      swallow        = 1'b0;
      in_buf_next    = in_buf_reg;
      cmd_next       = cmd_reg;
      out_buf_next   = out_buf_reg;
      user_next      = user_reg;
      pend_user_next = pend_user_reg;
      pend_val_next  = pend_val_reg;
      pend_clr_next  = pend_clr_reg;
      if (wr_end && gate_en_reg) begin
         if (wl_a0_reg && wl_data_reg == `SHP_CMD_GATE) begin
            gs_next = shp_pkg::SHP_GS_ARMED;
            swallow = 1'b1;
         end else if (!wl_a0_reg && gs_reg == shp_pkg::SHP_GS_ARMED) begin
            gate_next = wl_data_reg[1];
            gs_next   = shp_pkg::SHP_GS_DONE;
            swallow   = 1'b1;
         end else if (wl_a0_reg && wl_data_reg == `SHP_CMD_END &&
                      gs_reg == shp_pkg::SHP_GS_DONE) begin
            gs_next = shp_pkg::SHP_GS_IDLE;
            swallow = 1'b1;
         end else begin
            gs_next = shp_pkg::SHP_GS_IDLE;
         end
      end
      if (wr_end && !swallow) begin
         in_buf_next = wl_data_reg;
         cmd_next    = wl_a0_reg;
      end
      // hardware set wins over a CPU clear in the same cycle
      ibf_next = (ibf_reg & ~ibf_clr) | (wr_end & ~swallow);
      obf_next = (obf_reg & ~(rd_end & ~rl_a0_reg)) | fifo_pop;
      if (fifo_pop) begin
         out_buf_next = fifo_data;
      end
      if (i_cpu_in_rd && lock) begin
         pend_clr_next = 1'b1;
      end else if (!lock) begin
         pend_clr_next = 1'b0;
      end
      if (op_sts) begin
         pend_user_next = 1'b1;
         pend_val_next  = i_acc[`SHP_STS_USER_MSB:`SHP_STS_USER_LSB];
      end
      if ((op_sts || pend_user_reg) && !lock) begin
         user_next      = op_sts ? i_acc[`SHP_STS_USER_MSB:`SHP_STS_USER_LSB]
                                 : pend_val_reg;
         pend_user_next = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         gs_reg        <= shp_pkg::SHP_GS_IDLE;
         gate_reg      <= 1'b1;
         in_buf_reg    <= `SHP_RST_BYTE;
         cmd_reg       <= 1'b0;
         out_buf_reg   <= `SHP_RST_BYTE;
         ibf_reg       <= 1'b0;
         obf_reg       <= 1'b0;
         user_reg      <= `SHP_RST_USER;
         pend_user_reg <= 1'b0;
         pend_val_reg  <= `SHP_RST_USER;
         pend_clr_reg  <= 1'b0;
      end else begin
         gs_reg        <= gs_next;
         gate_reg      <= gate_next;
         in_buf_reg    <= in_buf_next;
         cmd_reg       <= cmd_next;
         out_buf_reg   <= out_buf_next;
         ibf_reg       <= ibf_next;
         obf_reg       <= obf_next;
         user_reg      <= user_next;
         pend_user_reg <= pend_user_next;
         pend_val_reg  <= pend_val_next;
         pend_clr_reg  <= pend_clr_next;
      end
   end

   // ------------------------------------------------------------
   // port 2 modes and pins
   // ------------------------------------------------------------
   always_comb begin
      dma_en_next   = dma_en_reg | op_dma;
      flags_en_next = flags_en_reg | op_flags;
      gate_en_next  = gate_en_reg | op_gate;
      p2_latch_next = i_p2_wr ? i_p2_data : p2_latch_reg;
      // a new request wins over a clear in the same cycle
      drq_next = (drq_reg & ~(op_dma | (wr_end & wl_ack_reg) | (rd_end & rl_ack_reg)))
               | (dma_en_reg & i_p2_wr & i_p2_data[`SHP_P2_REQ_BIT]);
      p2_out_next = p2_latch_reg;
      if (gate_en_reg) begin
         p2_out_next[`SHP_P2_GATE_BIT] = gate_reg;
      end
      if (flags_en_reg) begin
         p2_out_next[`SHP_P2_OUT_FLAG_BIT] = p2_latch_reg[`SHP_P2_OUT_FLAG_BIT] & obf_reg;
         p2_out_next[`SHP_P2_IN_FLAG_BIT]  = p2_latch_reg[`SHP_P2_IN_FLAG_BIT] & ~ibf_reg;
      end
      if (dma_en_reg) begin
         p2_out_next[`SHP_P2_REQ_BIT] = drq_reg;
         // acknowledge pin is an input now; keep it released high
         p2_out_next[`SHP_P2_ACK_BIT] = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dma_en_reg   <= 1'b0;
         flags_en_reg <= 1'b0;
         gate_en_reg  <= 1'b0;
         drq_reg      <= 1'b0;
         p2_latch_reg <= `SHP_RST_PORT2;
         p2_out_reg   <= `SHP_RST_PORT2;
      end else begin
         dma_en_reg   <= dma_en_next;
         flags_en_reg <= flags_en_next;
         gate_en_reg  <= gate_en_next;
         drq_reg      <= drq_next;
         p2_latch_reg <= p2_latch_next;
         p2_out_reg   <= p2_out_next;
      end
   end

   // ------------------------------------------------------------
   // CPU output queue and outputs
   // ------------------------------------------------------------
   shp_fifo #(
      .WIDTH (`SHP_DATA_W),
      .DEPTH (`SHP_FIFO_DEPTH)
   ) u_out_fifo (
      .i_ref_clk   (i_ref_clk),
      .i_rstn      (i_rstn),
      .i_in_data   (i_cpu_out_data),
      .i_in_valid  (i_cpu_out_valid),
      .o_in_ready  (o_cpu_out_ready),
      .o_out_data  (fifo_data),
      .o_out_valid (fifo_valid),
      .i_out_ready (fifo_pop)
   );

   assign o_host_data_buffer      = db_out_reg;
   assign o_host_data_buffer_oe_n = oe_n_reg;
   assign o_port2                 = p2_out_reg;
   assign o_cpu_in_data           = in_buf_reg;
   assign o_input_full_flag       = ibf_reg;
   assign o_command_data_flag     = cmd_reg;
   assign o_output_full_flag      = obf_reg;
endmodule

//--- dv/shp_host_port_properties.sv
// Purpose: timing relations between host strobes, CPU requests and flags
// Assumes: one clock; strobes kept three cycles low and four high
// Notes:   bound into shp_host_port below
`timescale 1ns/1ps
module shp_host_port_properties (
   input wire logic       i_ref_clk,
   input wire logic       i_rstn,
   input wire logic       i_rd_n,
   input wire logic       i_wr_n,
   input wire logic       i_cpu_in_rd,
   input wire logic       i_cpu_out_valid,
   input wire logic       o_cpu_out_ready,
   input wire logic       o_input_full_flag,
   input wire logic       o_output_full_flag,
   input wire logic       o_host_data_buffer_oe_n,
   input wire logic [7:0] o_port2
);
   logic [3:0] quiet_reg;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // strobe effects land within six cycles, so a longer quiet spell is free of them
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn)
         quiet_reg <= 4'h0;
      else if (!i_rd_n || !i_wr_n)
         quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hF)
         quiet_reg <= quiet_reg + 4'h1;
   end
   sequence s_quiet;
      quiet_reg > 4'h6;
   endsequence
   sequence s_wr_ended;
      i_wr_n && (!$past(i_wr_n, 2) || !$past(i_wr_n, 3) || !$past(i_wr_n, 4) ||
                 !$past(i_wr_n, 5) || !$past(i_wr_n, 6));
   endsequence
   sequence s_rd_ended;
      i_rd_n && (!$past(i_rd_n, 2) || !$past(i_rd_n, 3) || !$past(i_rd_n, 4) ||
                 !$past(i_rd_n, 5) || !$past(i_rd_n, 6));
   endsequence
   a_reset_pins_idle: assert property ($rose(i_rstn) |-> o_port2 == 8'hFF &&
      o_cpu_out_ready)
      else $error("port or queue not idle after reset");
   a_drive_only_read: assert property (!o_host_data_buffer_oe_n |->
      !$past(i_rd_n, 1) || !$past(i_rd_n, 2) || !$past(i_rd_n, 3) || !$past(i_rd_n, 4))
      else $error("data bus driven without a read");
   a_ibf_after_trailing: assert property ($rose(o_input_full_flag) |-> s_wr_ended)
      else $error("input full rose outside a write trailing edge");
   a_obf_clear_read: assert property ($fell(o_output_full_flag) |-> s_rd_ended)
      else $error("output full fell without a host read");
   a_obf_set_push: assert property (i_cpu_out_valid && o_cpu_out_ready &&
      !o_output_full_flag ##0 s_quiet |-> ##[1:3] o_output_full_flag)
      else $error("output full not set after CPU write");
   a_obf_holds_quiet: assert property (o_output_full_flag ##0 s_quiet |=>
      o_output_full_flag)
      else $error("output full dropped with no read");
   a_ibf_cpu_clear: assert property (i_cpu_in_rd ##0 s_quiet |=> !o_input_full_flag)
      else $error("input full not cleared by CPU read");
   a_ready_drop_push: assert property ($fell(o_cpu_out_ready) |-> $past(i_cpu_out_valid))
      else $error("queue became full without a write");
endmodule

bind shp_host_port shp_host_port_properties i_shp_host_port_properties (
   .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
   .i_cpu_in_rd(i_cpu_in_rd), .i_cpu_out_valid(i_cpu_out_valid),
   .o_cpu_out_ready(o_cpu_out_ready), .o_input_full_flag(o_input_full_flag),
   .o_output_full_flag(o_output_full_flag), .o_port2(o_port2),
   .o_host_data_buffer_oe_n(o_host_data_buffer_oe_n));

//--- dv/shp_host_model.sv
// Purpose: host processor and DMA controller facing the host port
// Assumes: strobes held four cycles or more low and six high
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
module shp_host_model (
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_q,
   input  wire logic       i_oe_n,
   output logic            o_cs_n,
   output logic            o_rd_n,
   output logic            o_wr_n,
   output logic            o_a,
   output logic            o_ack_n,
   output logic      [7:0] o_d
);
   initial begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_a = 1'b0;
      o_ack_n = 1'b1;
      o_d = 8'h00;
   end
   task automatic xfer(input logic rd, input logic dma, input logic a,
                       input logic [7:0] wd, output logic [7:0] rv);
      int n;
      @(posedge i_ref_clk);
      o_a <= a;
      o_cs_n <= dma;
      o_ack_n <= !dma;
      o_rd_n <= !rd;
      o_wr_n <= rd;
      o_d <= rd ? ~o_d : wd;
      n = 0;
      repeat (4) @(posedge i_ref_clk);
      while (rd && i_oe_n !== 1'b0 && n < 8) begin
         @(posedge i_ref_clk);
         n++;
      end
      rv = i_q;
      o_cs_n <= 1'b1;
      o_ack_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_d <= ~o_d;
      repeat (6) @(posedge i_ref_clk);
   endtask
endmodule

//--- dv/shp_host_port_tb.sv
// Purpose: self-checking bench of the slave host port
// Assumes: host model tasks pace the strobes
// Notes:   CPU side driven by one pulse task, except the queue fill loop and acc
`timescale 1ns/1ps
`include "shp_consts.svh"
module shp_host_port_tb;
   localparam logic [7:0] OP_FLAGS = 8'h01;
   localparam logic [7:0] OP_STS   = 8'h02;
   logic       ref_clk = 1'b0;
   logic       rstn = 1'b0;
   logic       cs_n, rd_n, wr_n, a, ack_n, oe_n, op_valid, p2_wr, in_rd, input_full_flag, cdf;
   logic       out_valid, ready, output_full_flag;
   logic [7:0] hd, q, port2, op, acc, p2_data, in_data, out_data, rv;
   logic [10:0] gs [0:9];
   int         n_fail = 0;
   int         checks_done = 0;
   int         cycles = 0;
   int         k;
   always #25 ref_clk = ~ref_clk;
   shp_host_port #(.P_OP_EN_FLAGS(OP_FLAGS), .P_OP_MOV_STS(OP_STS)) i_shp_host_port (
      .i_ref_clk(ref_clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
      .i_command_select_line(a), .i_host_data_buffer(hd), .o_host_data_buffer(q),
      .o_host_data_buffer_oe_n(oe_n), .i_acknowledge_port_pin_n(ack_n), .o_port2(port2),
      .i_op_valid(op_valid), .i_op(op), .i_acc(acc), .i_p2_wr(p2_wr), .i_p2_data(p2_data),
      .i_cpu_in_rd(in_rd), .o_cpu_in_data(in_data), .o_input_full_flag(input_full_flag),
      .o_command_data_flag(cdf), .i_cpu_out_data(out_data), .i_cpu_out_valid(out_valid),
      .o_cpu_out_ready(ready), .o_output_full_flag(output_full_flag));
   shp_host_model i_shp_host_model (
      .i_ref_clk(ref_clk), .i_q(q), .i_oe_n(oe_n), .o_cs_n(cs_n), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_a(a), .o_ack_n(ack_n), .o_d(hd));
   task end_of_test();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // a hang anywhere is cut short well past the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_fail++;
         end_of_test();
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // w: 0 opcode, 1 port write, 2 input read, 3 output word
   task pulse(input int w, input logic [7:0] v);
      @(posedge ref_clk);
      op <= v;
      p2_data <= v;
      out_data <= v;
      op_valid <= (w == 0);
      p2_wr <= (w == 1);
      in_rd <= (w == 2);
      out_valid <= (w == 3);
      @(posedge ref_clk);
      op_valid <= 1'b0;
      p2_wr <= 1'b0;
      in_rd <= 1'b0;
      out_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task hw(input logic sel, input logic [7:0] d);
      i_shp_host_model.xfer(1'b0, 1'b0, sel, d, rv);
   endtask
   task hr(input logic sel);
      i_shp_host_model.xfer(1'b1, 1'b0, sel, 8'h00, rv);
   endtask
   initial begin
      {op_valid, p2_wr, in_rd, out_valid} = 4'h0;
      {op, acc, p2_data, out_data} = 32'h0;
      gs = '{{1'b1, 8'hD1, 2'b10}, {1'b0, 8'hDD, 2'b00}, {1'b1, 8'hFF, 2'b00},
             {1'b1, 8'hD1, 2'b00}, {1'b1, 8'hD1, 2'b00}, {1'b0, 8'hDF, 2'b10},
             {1'b1, 8'hFF, 2'b10}, {1'b1, 8'hD1, 2'b10}, {1'b1, 8'h3C, 2'b11},
             {1'b0, 8'hDD, 2'b11}};
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      #1;
      chk(port2, `SHP_RST_PORT2);
      chk({4'h0, ready, input_full_flag, output_full_flag, oe_n}, 8'h09);
      hw(1'b0, 8'h5A);
      chk({in_data[6:0], input_full_flag}, {7'h5A, 1'b1});
      chk({7'h0, cdf}, 8'h00);
      pulse(2, 8'h00);
      chk({7'h0, input_full_flag}, 8'h00);
      hw(1'b1, 8'h3C);
      chk({6'h0, input_full_flag, cdf}, 8'h03);
      pulse(2, 8'h00);
      k = 0;
      out_valid <= 1'b1;
      out_data <= 8'h00;
      while (k < 40) begin
         @(posedge ref_clk);
         if (ready !== 1'b1)
            break;
         k++;
         out_data <= 8'(k);
      end
      out_valid <= 1'b0;
      chk(8'(k), 8'(`SHP_FIFO_DEPTH + 1));
      hr(1'b1);
      chk(rv, 8'h09);
      for (k = 0; k <= `SHP_FIFO_DEPTH; k++) begin
         hr(1'b0);
         chk(rv, 8'(k));
      end
      chk({6'h0, output_full_flag, ready}, 8'h01);
      acc <= 8'hA5;
      pulse(0, OP_STS);
      hr(1'b1);
      chk(rv, 8'hA8);
      acc <= 8'h30;
      fork
         hr(1'b1);
         #125 pulse(0, OP_STS);
      join
      hr(1'b1);
      chk(rv, 8'h38);
      pulse(0, OP_FLAGS);
      chk(port2, 8'hEF);
      pulse(3, 8'h66);
      chk(port2, 8'hFF);
      hw(1'b0, 8'h11);
      chk(port2, 8'hDF);
      pulse(2, 8'h00);
      pulse(1, 8'h4F);
      chk(port2, 8'h4F);
      pulse(0, `SHP_OP_EN_DMA);
      chk(port2, 8'h8F);
      pulse(1, 8'h40);
      chk(port2, 8'hC0);
      i_shp_host_model.xfer(1'b0, 1'b1, 1'b0, 8'h77, rv);
      chk(port2, 8'h80);
      chk({in_data[6:0], input_full_flag}, {7'h77, 1'b1});
      pulse(2, 8'h00);
      pulse(1, 8'h40);
      pulse(0, `SHP_OP_EN_DMA);
      chk(port2, 8'h80);
      pulse(0, `SHP_OP_GATE_EN);
      pulse(1, 8'h40);
      chk(port2, 8'hC2);
      for (k = 0; k < 10; k++) begin
         hw(gs[k][10], gs[k][9:2]);
         chk(port2, {6'b110000, gs[k][1], 1'b0});
         chk({7'h0, input_full_flag}, {7'h0, gs[k][0]});
      end
      chk(in_data, 8'hDD);
      pulse(2, 8'h00);
      hw(1'b1, `SHP_CMD_END);
      chk({7'h0, input_full_flag}, 8'h01);
      end_of_test();
   end
endmodule
